// ---- core/uart_ext_pkg.sv ----
/*
 * Shared constants and carrier types for the serial port extension block:
 * register offsets, field positions, reset values and bus encodings.
 * Assumes a 32-bit AHB-Lite register bus and an 8-bit offset window.
 */
`default_nettype none

package uart_ext_pkg;

	localparam int FRACTION_WIDTH = 4;
	localparam int CHAR_W         = 9;
	localparam int DIV_W          = 16;
	localparam int OFS_W          = 8;

	// Register byte offsets inside the block's window.
	localparam logic [OFS_W-1:0] OFS_DMA_REQUEST_ABORT        = 8'ha8;
	localparam logic [OFS_W-1:0] OFS_BAUD_DIVISOR_FRACTION    = 8'hc0;
	localparam logic [OFS_W-1:0] OFS_RECEIVE_MATCH_ADDRESS    = 8'hc4;
	localparam logic [OFS_W-1:0] OFS_TRANSMIT_STATION_ADDRESS = 8'hc8;
	localparam logic [OFS_W-1:0] OFS_LINE_EXTENSION_CONTROL   = 8'hcc;
	localparam logic [OFS_W-1:0] OFS_BAUD_DIVISOR_INTEGER     = 8'hd0;
	localparam logic [OFS_W-1:0] OFS_EXTENSION_STATUS         = 8'hd4;

	// Field positions.
	localparam int DMA_ABORT_BIT   = 0;
	localparam int LEXT_NINE_BIT   = 0;
	localparam int LEXT_FILTER_BIT = 1;
	localparam int LEXT_SEND_BIT   = 2;
	localparam int STAT_MATCH_BIT  = 0;
	localparam int STAT_ADDR_BIT   = 1;

	// Values after reset.
	localparam logic [FRACTION_WIDTH-1:0] RST_FRACTION = 4'h0;
	localparam logic [7:0]                RST_ADDRESS  = 8'h00;
	localparam logic [3:0]                RST_LINE_EXT = 4'h0;
	localparam logic [DIV_W-1:0]          RST_DIVISOR  = 16'h0001;

	// Bus encodings.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef struct packed {
		logic tx_burst;
		logic tx_single;
		logic rx_burst;
		logic rx_single;
	} dma_req_t;

	typedef struct packed {
		logic transmit_width_select;
		logic send_address_pending;
		logic addr_filter_enable;
		logic nine_bit_char_enable;
	} line_ext_t;

endpackage

`default_nettype wire

// ---- core/uart_addr_match_frac_baud.sv ----
/*
 * Serial port extension: multidrop address filter and address insertion,
 * fractional baud divisor and software DMA request abort, behind an
 * AHB-Lite slave. Assumes the transmit FIFO, receive FIFO, serial engine
 * and DMA request logic of the port sit outside on the same clock.
 */
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module uart_addr_match_frac_baud
	import uart_ext_pkg::*;
#(
	parameter int DIVISOR_WIDTH = DIV_W
) (
	input  wire logic              core_clk_in,
	input  wire logic              nrst_in,
	input  wire logic              hsel_in,
	input  wire logic [31:0]       haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic [2:0]        hsize_in,
	input  wire logic [31:0]       hwdata_in,
	input  wire logic              hready_in,
	output logic      [31:0]       hrdata_out,
	output logic                   hreadyout_out,
	output logic                   hresp_out,
	input  wire dma_req_t          dma_req_in,
	output dma_req_t               dma_req_out,
	input  wire logic [CHAR_W-1:0] tx_fifo_data_in,
	input  wire logic              tx_fifo_valid_in,
	output logic                   tx_fifo_ready_out,
	output logic      [CHAR_W-1:0] tx_char_out,
	output logic                   tx_char_valid_out,
	input  wire logic              tx_char_ready_in,
	input  wire logic [CHAR_W-1:0] rx_char_in,
	input  wire logic              rx_char_valid_in,
	output logic      [CHAR_W-1:0] rx_wr_data_out,
	output logic                   rx_wr_valid_out,
	output logic                   baud_tick_out,
	output line_ext_t              line_ext_out
);

	logic                      wr_pend_r;
	logic [OFS_W-1:0]          acc_ofs_r;
	logic [FRACTION_WIDTH-1:0] frac_r;
	logic [7:0]                rx_match_r;
	logic [7:0]                tx_station_r;
	line_ext_t                 lext_r;
	line_ext_t                 lext_nxt;
	logic [DIVISOR_WIDTH-1:0]  div_int_r;
	logic                      abort_r;
	logic [3:0]                hold_r;
	logic [3:0]                hold_nxt;
	logic [DIVISOR_WIDTH-1:0]  cnt_r;
	logic [FRACTION_WIDTH-1:0] acc_r;
	logic [FRACTION_WIDTH:0]   acc_sum;
	logic                      matched_r;
	logic [CHAR_W-1:0]         char_r;
	logic                      char_valid_r;
	logic                      char_is_addr_r;

	logic addr_ph;
	logic match_en;
	logic send_active;
	logic can_load;
	logic addr_taken;
	logic load_addr;
	logic load_data;

	function automatic logic reg_write(input logic pend, input logic [OFS_W-1:0] ofs,
		input logic [OFS_W-1:0] target);
		reg_write = pend && (ofs == target);
	endfunction

	// A write is taken only as a whole word; other sizes complete with no effect.
	assign addr_ph       = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			wr_pend_r <= 1'b0;
			acc_ofs_r <= '0;
		end else if (hready_in) begin
			wr_pend_r <= addr_ph && hwrite_in && (hsize_in == HSIZE_WORD);
			acc_ofs_r <= addr_ph ? haddr_in[OFS_W-1:0] : '0;
		end
	end

	// Read data is chosen in the data phase, so a read right after a write sees it.
	always_comb begin
		hrdata_out = 32'h0000_0000;
		unique case (acc_ofs_r)
			OFS_BAUD_DIVISOR_FRACTION:    hrdata_out[FRACTION_WIDTH-1:0] = frac_r;
			OFS_RECEIVE_MATCH_ADDRESS:    hrdata_out[7:0] = rx_match_r;
			OFS_TRANSMIT_STATION_ADDRESS: hrdata_out[7:0] = tx_station_r;
			OFS_LINE_EXTENSION_CONTROL:   hrdata_out[3:0] = lext_r;
			OFS_BAUD_DIVISOR_INTEGER:     hrdata_out[DIVISOR_WIDTH-1:0] = div_int_r;
			OFS_EXTENSION_STATUS: begin
				hrdata_out[STAT_MATCH_BIT] = matched_r;
				hrdata_out[STAT_ADDR_BIT]  = char_valid_r && char_is_addr_r;
			end
			default:                      hrdata_out = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			frac_r       <= RST_FRACTION;
			rx_match_r   <= RST_ADDRESS;
			tx_station_r <= RST_ADDRESS;
			div_int_r    <= RST_DIVISOR;
		end else begin
			if (reg_write(wr_pend_r, acc_ofs_r, OFS_BAUD_DIVISOR_FRACTION))
				frac_r <= hwdata_in[FRACTION_WIDTH-1:0];
			if (reg_write(wr_pend_r, acc_ofs_r, OFS_RECEIVE_MATCH_ADDRESS))
				rx_match_r <= hwdata_in[7:0];
			if (reg_write(wr_pend_r, acc_ofs_r, OFS_TRANSMIT_STATION_ADDRESS))
				tx_station_r <= hwdata_in[7:0];
			if (reg_write(wr_pend_r, acc_ofs_r, OFS_BAUD_DIVISOR_INTEGER))
				div_int_r <= hwdata_in[DIVISOR_WIDTH-1:0];
		end
	end

	// A software write of one beats the hardware clear in the same cycle.
	always_comb begin
		lext_nxt = lext_r;
		if (addr_taken)
			lext_nxt.send_address_pending = 1'b0;
		if (reg_write(wr_pend_r, acc_ofs_r, OFS_LINE_EXTENSION_CONTROL))
			lext_nxt = line_ext_t'(hwdata_in[3:0]);
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in)
			lext_r <= line_ext_t'(RST_LINE_EXT);
		else
			lext_r <= lext_nxt;
	end

	assign line_ext_out = lext_r;

	// The abort holds each request low until the requester drops it.
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in)
			abort_r <= 1'b0;
		else
			abort_r <= reg_write(wr_pend_r, acc_ofs_r, OFS_DMA_REQUEST_ABORT)
				&& hwdata_in[DMA_ABORT_BIT];
	end

	assign hold_nxt = abort_r ? 4'hf : (hold_r & dma_req_in);

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			hold_r      <= 4'h0;
			dma_req_out <= '0;
		end else begin
			hold_r      <= hold_nxt;
			dma_req_out <= dma_req_t'(dma_req_in & ~hold_nxt);
		end
	end

	// The carry of a four-bit accumulator stretches F periods in sixteen by one.
	assign acc_sum = {1'b0, acc_r} + {1'b0, frac_r};

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			cnt_r         <= '0;
			acc_r         <= '0;
			baud_tick_out <= 1'b0;
		end else if (div_int_r == '0) begin
			cnt_r         <= '0;
			baud_tick_out <= 1'b0;
		end else if (cnt_r == '0) begin
			acc_r         <= acc_sum[FRACTION_WIDTH-1:0];
			cnt_r         <= div_int_r - DIVISOR_WIDTH'(1)
				+ DIVISOR_WIDTH'(acc_sum[FRACTION_WIDTH]);
			baud_tick_out <= 1'b1;
		end else begin
			cnt_r         <= cnt_r - DIVISOR_WIDTH'(1);
			baud_tick_out <= 1'b0;
		end
	end

	assign match_en = lext_r.addr_filter_enable && lext_r.nine_bit_char_enable;

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			matched_r       <= 1'b0;
			rx_wr_valid_out <= 1'b0;
			rx_wr_data_out  <= '0;
		end else begin
			rx_wr_valid_out <= 1'b0;
			if (!match_en) begin
				matched_r <= 1'b0;
				if (rx_char_valid_in) begin
					rx_wr_valid_out <= 1'b1;
					rx_wr_data_out  <= lext_r.nine_bit_char_enable ? rx_char_in
						: {1'b0, rx_char_in[7:0]};
				end
			end else if (rx_char_valid_in && rx_char_in[8]) begin
				matched_r <= (rx_char_in[7:0] == rx_match_r);
			end else if (rx_char_valid_in && matched_r) begin
				rx_wr_valid_out <= 1'b1;
				rx_wr_data_out  <= rx_char_in;
			end
		end
	end

	assign send_active = lext_r.nine_bit_char_enable && !lext_r.transmit_width_select
		&& lext_r.send_address_pending;
	assign can_load    = !char_valid_r || tx_char_ready_in;
	assign addr_taken  = char_valid_r && tx_char_ready_in && char_is_addr_r;
	// An address already waiting must not be queued a second time.
	assign load_addr   = can_load && send_active && !(char_valid_r && char_is_addr_r);
	assign load_data   = can_load && !send_active && tx_fifo_valid_in;
	assign tx_fifo_ready_out = can_load && !send_active;

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			char_valid_r   <= 1'b0;
			char_is_addr_r <= 1'b0;
			char_r         <= '0;
		end else if (load_addr) begin
			char_valid_r   <= 1'b1;
			char_is_addr_r <= 1'b1;
			char_r         <= {1'b1, tx_station_r};
		end else if (load_data) begin
			char_valid_r   <= 1'b1;
			char_is_addr_r <= 1'b0;
			char_r         <= (lext_r.nine_bit_char_enable && lext_r.transmit_width_select)
				? tx_fifo_data_in : {1'b0, tx_fifo_data_in[7:0]};
		end else if (tx_char_ready_in) begin
			char_valid_r   <= 1'b0;
			char_is_addr_r <= 1'b0;
		end
	end

	assign tx_char_out       = char_r;
	assign tx_char_valid_out = char_valid_r;

	// Helper state for the period checks; any divisor write voids the history.
	logic [DIVISOR_WIDTH:0] per_r;
	logic [DIVISOR_WIDTH:0] exp_r;
	logic [3:0]             ticks_r;
	logic [4:0]             carries_r;
	logic [4:0]             seen_r;
	logic                   div_wr;
	logic                   reload;

	assign div_wr = reg_write(wr_pend_r, acc_ofs_r, OFS_BAUD_DIVISOR_FRACTION)
		|| reg_write(wr_pend_r, acc_ofs_r, OFS_BAUD_DIVISOR_INTEGER);
	assign reload = (div_int_r != '0) && (cnt_r == '0);

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in || div_wr) begin
			per_r     <= '0;
			exp_r     <= '0;
			ticks_r   <= '0;
			carries_r <= '0;
			seen_r    <= '0;
		end else if (reload) begin
			per_r     <= '0;
			exp_r     <= {1'b0, div_int_r} + (DIVISOR_WIDTH+1)'(acc_sum[FRACTION_WIDTH]);
			ticks_r   <= ticks_r + 4'h1;
			carries_r <= (ticks_r == 4'hf) ? 5'h00 : carries_r + 5'(acc_sum[FRACTION_WIDTH]);
			seen_r    <= (seen_r == 5'h1f) ? seen_r : seen_r + 5'h01;
		end else begin
			per_r     <= per_r + (DIVISOR_WIDTH+1)'(1);
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_abort_write;
		reg_write(wr_pend_r, acc_ofs_r, OFS_DMA_REQUEST_ABORT) && hwdata_in[DMA_ABORT_BIT];
	endsequence

	property p_abort_withdraws;
		s_abort_write ##1 abort_r |=> (dma_req_out == '0);
	endproperty
	a_abort_withdraws: assert property (p_abort_withdraws)
		else $error("DMA requests not withdrawn after abort.");

	property p_abort_self_clears;
		s_abort_write ##1 (abort_r && !$past(abort_r)) |=> !abort_r;
	endproperty
	a_abort_self_clears: assert property (p_abort_self_clears)
		else $error("Abort bit did not clear itself.");

	property p_period_length;
		reload && seen_r >= 5'h02 |-> (per_r + (DIVISOR_WIDTH+1)'(1) == exp_r);
	endproperty
	a_period_length: assert property (p_period_length)
		else $error("Bit period differs from integer divisor plus carry.");

	property p_fraction_sixteenths;
		reload && seen_r >= 5'h10 && ticks_r == 4'hf
			|-> (carries_r + 5'(acc_sum[FRACTION_WIDTH]) == {1'b0, frac_r});
	endproperty
	a_fraction_sixteenths: assert property (p_fraction_sixteenths)
		else $error("Sixteen periods did not stretch by the fraction field.");

	property p_address_compare;
		match_en && rx_char_valid_in && rx_char_in[8]
			|=> (matched_r == ($past(rx_char_in[7:0]) == $past(rx_match_r))) && !rx_wr_valid_out;
	endproperty
	a_address_compare: assert property (p_address_compare)
		else $error("Address character compare result wrong.");

	property p_data_after_match;
		match_en && matched_r && rx_char_valid_in && !rx_char_in[8]
			|=> rx_wr_valid_out && (rx_wr_data_out == $past(rx_char_in));
	endproperty
	a_data_after_match: assert property (p_data_after_match)
		else $error("Data after a match not passed to the receive FIFO.");

	property p_filter_gate;
		match_en && !matched_r && rx_char_valid_in |=> !rx_wr_valid_out;
	endproperty
	a_filter_gate: assert property (p_filter_gate)
		else $error("Character passed while no address matched.");

	property p_unfiltered_pass;
		!match_en && lext_r.nine_bit_char_enable && rx_char_valid_in
			|=> rx_wr_valid_out && (rx_wr_data_out == $past(rx_char_in));
	endproperty
	a_unfiltered_pass: assert property (p_unfiltered_pass)
		else $error("Unfiltered nine-bit character not placed into the FIFO.");

	sequence s_addr_loaded;
		load_addr ##1 (char_valid_r && char_is_addr_r);
	endsequence

	property p_address_char;
		load_addr |=> (tx_char_out == {1'b1, $past(tx_station_r)}) && tx_char_valid_out;
	endproperty
	a_address_char: assert property (p_address_char)
		else $error("Address character content wrong.");

	property p_send_clears;
		s_addr_loaded ##0 tx_char_ready_in
			##1 !$past(reg_write(wr_pend_r, acc_ofs_r, OFS_LINE_EXTENSION_CONTROL))
			|-> !lext_r.send_address_pending;
	endproperty
	a_send_clears: assert property (p_send_clears)
		else $error("Send-address bit not cleared when the address started.");

	property p_send_needs_mode;
		lext_r.transmit_width_select || !lext_r.nine_bit_char_enable |-> !load_addr;
	endproperty
	a_send_needs_mode: assert property (p_send_needs_mode)
		else $error("Address character inserted outside eight-bit nine-bit mode.");

	property p_abort_reads_zero;
		hsel_in && hready_in && htrans_in == HTRANS_NONSEQ && !hwrite_in
			&& haddr_in[OFS_W-1:0] == OFS_DMA_REQUEST_ABORT |=> hrdata_out == 32'h0000_0000;
	endproperty
	a_abort_reads_zero: assert property (p_abort_reads_zero)
		else $error("Abort register read returned nonzero.");

endmodule

`default_nettype wire

// ---- bench/remote_node.sv ----
/*
 * Model of the remote serial side: it takes characters from the block's
 * transmit handshake, promptly or with random stalls, and sends received
 * characters one at a time. Assumes one clock shared with the block.
 */
`timescale 1ns/1ps
`default_nettype none

module remote_node (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic [8:0] tx_char_in,
	input  wire logic       tx_valid_in,
	output var logic        tx_ready_out,
	output var logic  [8:0] rx_char_out,
	output var logic        rx_valid_out
);
	int          seed = 9;
	logic        slow = 1'b0;
	logic [8:0]  got[$];
	logic [31:0] r;

	initial begin
		tx_ready_out = 1'b0;
		rx_char_out = 9'h000;
		rx_valid_out = 1'b0;
	end

	// Stalls keep the held character standing for several cycles.
	always @(posedge clk_in) begin
		r = $random(seed);
		if (tx_valid_in && tx_ready_out) begin
			got.push_back(tx_char_in);
		end
		tx_ready_out <= nrst_in && (!slow || r[0]);
	end

	// The line is driven to the inverse after a character so stale data never looks valid.
	task send(input logic [8:0] c);
		@(posedge clk_in);
		rx_char_out <= c;
		rx_valid_out <= 1'b1;
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_char_out <= ~c;
	endtask
endmodule

`default_nettype wire

// ---- bench/uart_addr_match_frac_baud_tb.sv ----
/*
 * Self-checking bench for the serial port extension block: registers over
 * AHB-Lite, DMA abort, fractional baud ticks, receive filter and address send.
 * Assumes the remote node model drives the engine side of the block.
 */
`timescale 1ns/1ps
`default_nettype none

module uart_addr_match_frac_baud_tb;
	import uart_ext_pkg::*;

	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hrdy;
	logic        hresp;
	dma_req_t    dreq_i = '0;
	dma_req_t    dreq_o;
	logic [8:0]  txd = 9'h000;
	logic        txv = 1'b0;
	logic        txr;
	logic [8:0]  tch;
	logic        tcv;
	wire logic   tcr;
	wire logic [8:0] rch;
	wire logic   rcv;
	logic [8:0]  rwd;
	logic        rwv;
	logic        tick;
	line_ext_t   lext;
	int          seed = 9;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	logic [8:0]  txq[$];
	logic [8:0]  rxq[$];
	logic [8:0]  exq[$];
	logic [3:0]  le;
	logic [7:0]  ma;
	logic [7:0]  st;
	logic        hit = 1'b0;
	logic [31:0] r;
	int          nt = 0;
	logic [7:0]  ofs[3] = '{OFS_BAUD_DIVISOR_FRACTION, OFS_RECEIVE_MATCH_ADDRESS,
		OFS_TRANSMIT_STATION_ADDRESS};
	logic [31:0] msk[3] = '{32'h0000000f, 32'h000000ff, 32'h000000ff};
	logic [3:0]  les[4] = '{4'h3, 4'h1, 4'h2, 4'h3};

	always #2 clk = ~clk;

	uart_addr_match_frac_baud dut_u (
		.core_clk_in(clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
		.dma_req_in(dreq_i), .dma_req_out(dreq_o), .tx_fifo_data_in(txd),
		.tx_fifo_valid_in(txv), .tx_fifo_ready_out(txr), .tx_char_out(tch),
		.tx_char_valid_out(tcv), .tx_char_ready_in(tcr), .rx_char_in(rch),
		.rx_char_valid_in(rcv), .rx_wr_data_out(rwd), .rx_wr_valid_out(rwv),
		.baud_tick_out(tick), .line_ext_out(lext)
	);

	remote_node node_u (
		.clk_in(clk), .nrst_in(nrst), .tx_char_in(tch), .tx_valid_in(tcv),
		.tx_ready_out(tcr), .rx_char_out(rch), .rx_valid_out(rcv)
	);

	task print_verdict;
		$display("errors %0d checks %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		q = hrdata;
		chk("response", 32'h0, {31'h0, hresp});
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
		if (a == OFS_LINE_EXTENSION_CONTROL) begin
			le = d[3:0];
		end
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk($sformatf("register %h", a), e, q);
	endtask

	// Expected receive path: matched data only while filtering, everything otherwise.
	task rxc(input logic [8:0] c);
		if (le[0] && le[1]) begin
			if (c[8]) begin
				hit = (c[7:0] == ma);
			end else if (hit) begin
				exq.push_back(c);
			end
		end else begin
			hit = 1'b0;
			exq.push_back(le[0] ? c : {1'b0, c[7:0]});
		end
		node_u.send(c);
	endtask

	// Sixteen periods of d cycles, stretched by one cycle for each sixteenth in f.
	function automatic logic [31:0] exp_span(input logic [15:0] d, input logic [3:0] f);
		exp_span = {12'h0, d, 4'h0} + {28'h0, f};
	endfunction

	task baud(input logic [3:0] f);
		int n;
		int t;
		wr(OFS_BAUD_DIVISOR_FRACTION, {28'h0, f});
		n = 0;
		t = -2;
		while (t < 16 && n < 500) begin
			@(posedge clk);
			if (t >= 0) begin
				n++;
			end
			if (tick === 1'b1) begin
				t++;
			end
		end
		chk("sixteen tick periods", exp_span(16'h0003, f), n);
	endtask

	task txwait(input int k);
		int n;
		n = 0;
		while (node_u.got.size() < k && n < 400) begin
			@(posedge clk);
			n++;
		end
	endtask

	always @(posedge clk) begin
		if (txv && txr) begin
			void'(txq.pop_front());
		end
		txv <= txq.size() > 0;
		txd <= txq.size() > 0 ? txq[0] : 9'h155;
		if (rwv === 1'b1) begin
			rxq.push_back(rwd);
		end
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rd(OFS_BAUD_DIVISOR_INTEGER, 32'h1);
		rd(OFS_LINE_EXTENSION_CONTROL, 32'h0);
		chk("line ext out", 32'h0, {28'h0, lext});
		for (int i = 0; i < 3; i++) begin
			rd(ofs[i], 32'h0);
			r = $random(seed);
			wr(ofs[i], r);
			rd(ofs[i], r & msk[i]);
		end
		rd(OFS_DMA_REQUEST_ABORT, 32'h0);
		wr(8'he0, 32'hffffffff);
		rd(8'he0, 32'h0);
		dreq_i <= 4'hf;
		repeat (3) @(posedge clk);
		chk("dma requests", 32'hf, {28'h0, dreq_o});
		wr(OFS_DMA_REQUEST_ABORT, 32'h1);
		repeat (3) @(posedge clk);
		chk("dma after abort", 32'h0, {28'h0, dreq_o});
		dreq_i <= 4'h0;
		@(posedge clk);
		dreq_i <= 4'ha;
		repeat (3) @(posedge clk);
		chk("dma after release", 32'ha, {28'h0, dreq_o});
		wr(OFS_BAUD_DIVISOR_INTEGER, 32'h3);
		baud(4'h0);
		baud(4'hf);
		r = $random(seed);
		baud(r[3:0]);
		// A zero divisor parks the generator; the tick launched at the write edge is skipped.
		wr(OFS_BAUD_DIVISOR_INTEGER, 32'h0);
		@(posedge clk);
		nt = 0;
		repeat (32) @(posedge clk) nt += int'(tick);
		chk("ticks with zero divisor", 32'h0, nt);
		wr(OFS_BAUD_DIVISOR_INTEGER, 32'h3);
		// Back to filtering last, so a match flag cleared by filter-off is exercised.
		ma = 8'($random(seed));
		wr(OFS_RECEIVE_MATCH_ADDRESS, {24'h0, ma});
		// A narrow write completes on the bus but must leave the match address alone.
		hsize <= 3'h0;
		wr(OFS_RECEIVE_MATCH_ADDRESS, {24'h0, ~ma});
		hsize <= HSIZE_WORD;
		rd(OFS_RECEIVE_MATCH_ADDRESS, {24'h0, ma});
		for (int k = 0; k < 4; k++) begin
			wr(OFS_LINE_EXTENSION_CONTROL, {28'h0, les[k]});
			for (int j = 0; j < 16; j++) begin
				r = $random(seed);
				rxc({r[8], r[9] ? ma : r[7:0]});
			end
			repeat (4) @(posedge clk);
			chk("rx count", 32'(exq.size()), 32'(rxq.size()));
			foreach (exq[i]) begin
				chk("rx char", {23'h0, exq[i]}, {23'h0, rxq[i]});
			end
			exq.delete();
			rxq.delete();
		end
		rd(OFS_EXTENSION_STATUS, {31'h0, hit});
		st = 8'($random(seed));
		node_u.slow = 1'b1;
		wr(OFS_TRANSMIT_STATION_ADDRESS, {24'h0, st});
		wr(OFS_LINE_EXTENSION_CONTROL, 32'h5);
		r = $random(seed);
		txq.push_back({1'b1, r[7:0]});
		txq.push_back({1'b1, r[15:8]});
		txwait(3);
		chk("address char", {23'h0, 1'b1, st}, {23'h0, node_u.got[0]});
		chk("data char", {24'h0, r[7:0]}, {23'h0, node_u.got[1]});
		chk("data char", {24'h0, r[15:8]}, {23'h0, node_u.got[2]});
		rd(OFS_LINE_EXTENSION_CONTROL, 32'h1);
		chk("line ext out", 32'h1, {28'h0, lext});
		wr(OFS_LINE_EXTENSION_CONTROL, 32'hd);
		txq.push_back({1'b1, ~st});
		txwait(4);
		chk("nine-bit holding", {23'h0, 1'b1, ~st}, {23'h0, node_u.got[3]});
		chk("line ext out", 32'hd, {28'h0, lext});
		print_verdict();
	end
endmodule

`default_nettype wire
